// ==== common/mlm_consts.svh ====
// Timing counts, thresholds and reset values of the meter leak monitor
`ifndef MLM_CONSTS_SVH
`define MLM_CONSTS_SVH
`define MLM_SEC_NS 1000000000
`define MLM_CLK_PERIOD_NS 100
`define MLM_INTEG_MAINS_S 4'h2
`define MLM_INTEG_BATT_S 4'h8
`define MLM_BACKLIGHT_S 5'h0F
`define MLM_BL_CODE_TIMED 4'h4
`define MLM_BL_CODE_ON 4'h9
`define MLM_LEAK_WINDOW_S 86400
`define MLM_BURST_WINDOW_S 120
`define MLM_COLD_HALF_HOUR_S 1800
`define MLM_COLD_DEFAULT_CODE 2'h2
`define MLM_COLD_SUBS_HALF 6'h30
`define MLM_COLD_SUBS_ONE 6'h18
`define MLM_COLD_SUBS_TWO 6'h0C
`define MLM_LEAK_PM_WIDE 48'h00000000000A
`define MLM_LEAK_PM_NARROW 48'h000000000005
`define MLM_LEAK_PC_WIDE 48'h000000000014
`define MLM_LEAK_PC_NARROW 48'h00000000000A
`define MLM_PC_SCALE 48'h00000000000A
`define MLM_LEAK_SCALE 64'h00000000000003E8
`define MLM_BURST_FACTOR 48'h000000000018
`endif

// ==== common/mlm_pkg.sv ====
// Types of the meter leak monitor
`default_nettype none
package mlm_pkg;
  typedef logic [15:0] mlm_flow_type;
  typedef logic signed [47:0] mlm_acc_type;
  typedef enum logic [1:0]
  {
    MLM_COLD_OFF = 2'b00,
    MLM_COLD_HALF = 2'b01,
    MLM_COLD_ONE = 2'b10,
    MLM_COLD_TWO = 2'b11
  } mlm_cold_mode_type;
endpackage
`default_nettype wire

// ==== hdl/mlm_sec_timer.sv ====
// One-second timebase of the meter leak monitor
`timescale 1ns/1ps
`default_nettype none
module mlm_sec_timer
#(
  parameter int unsigned SEC_CYCLES = 10000000
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Timebase
  output logic sec_pulse
);
  logic [31:0] cnt;
  logic [31:0] next_cnt;
  logic next_sec_pulse;

  always_comb
  begin
    next_cnt = cnt + 32'h00000001;
    next_sec_pulse = 1'b0;
    if (cnt >= SEC_CYCLES - 1)
    begin
      next_cnt = 32'h00000000;
      next_sec_pulse = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cnt <= 32'h00000000;
      sec_pulse <= 1'b0;
    end
    else
    begin
      cnt <= next_cnt;
      sec_pulse <= next_sec_pulse;
    end
  end
endmodule
`default_nettype wire

// ==== hdl/mlm_meter_leak_monitor.sv ====
// Integration tick, backlight, flow leak/burst and cold water leak supervision
`timescale 1ns/1ps
`default_nettype none
`include "mlm_consts.svh"
module mlm_meter_leak_monitor
#(
  parameter int unsigned SEC_CYCLES = `MLM_SEC_NS / `MLM_CLK_PERIOD_NS,
  parameter int unsigned LEAK_WINDOW_S = `MLM_LEAK_WINDOW_S,
  parameter int unsigned BURST_WINDOW_S = `MLM_BURST_WINDOW_S,
  parameter int unsigned COLD_UNIT_S = `MLM_COLD_HALF_HOUR_S
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Supply and keypad pins
  input wire logic mains_present,
  input wire logic key_press,
  // Configuration
  input wire logic [3:0] backlight_code,
  input wire logic [2:0] leak_limit_code,
  input wire logic cold_code_valid,
  input wire logic [1:0] cold_code,
  input wire logic cold_supervise_b,
  // Flow values
  input wire mlm_pkg::mlm_flow_type flow_input_one,
  input wire mlm_pkg::mlm_flow_type flow_input_two,
  input wire mlm_pkg::mlm_flow_type nominal_flow,
  // Cold water pulse pins
  input wire logic cold_pulse_a,
  input wire logic cold_pulse_b,
  // Status
  output logic integ_tick,
  output logic heartbeat,
  output logic backlight_on,
  output logic leak_flag,
  output logic burst_flag,
  output logic [1:0] cold_leak_flag
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  // ***************
  // Synchronisers
  // ***************
  logic [3:0] sync1;
  logic [3:0] sync2;
  logic [3:0] sync3;
  logic sec_pulse;
  logic mains_s;
  logic key_edge;
  logic [1:0] pulse_edge;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sync1 <= 4'h0;
      sync2 <= 4'h0;
      sync3 <= 4'h0;
    end
    else
    begin
      sync1 <= {cold_pulse_b, cold_pulse_a, key_press, mains_present};
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  assign mains_s = sync2[0];
  assign key_edge = sync2[1] & ~sync3[1];
  assign pulse_edge = sync2[3:2] & ~sync3[3:2];

  mlm_sec_timer #(.SEC_CYCLES(SEC_CYCLES)) u_sec
  (
    .clk(clk),
    .reset_n(reset_n),
    .sec_pulse(sec_pulse)
  );

  function automatic logic [47:0] mlm_abs(input mlm_pkg::mlm_acc_type v);
    mlm_abs = v[47] ? 48'(-v) : 48'(v);
  endfunction

  // ***************
  // Timing group
  // ***************
  logic [3:0] integ_cnt;
  logic [3:0] period;
  logic [4:0] bl_cnt;
  logic [3:0] next_integ_cnt;
  logic [4:0] next_bl_cnt;
  logic next_integ_tick;
  logic next_heartbeat;
  logic next_backlight_on;

  always_comb
  begin
    period = mains_s ? `MLM_INTEG_MAINS_S : `MLM_INTEG_BATT_S;
    next_integ_cnt = integ_cnt;
    next_integ_tick = 1'b0;
    next_heartbeat = heartbeat;
    next_bl_cnt = bl_cnt;
    if (sec_pulse)
    begin
      next_heartbeat = ~heartbeat;
      if (integ_cnt + 4'h1 >= period)
      begin
        next_integ_cnt = 4'h0;
        next_integ_tick = 1'b1;
      end
      else
      begin
        next_integ_cnt = integ_cnt + 4'h1;
      end
      if (bl_cnt < `MLM_BACKLIGHT_S)
      begin
        next_bl_cnt = bl_cnt + 5'h01;
      end
    end
    if (key_edge)
    begin
      next_bl_cnt = 5'h00;
    end
    next_backlight_on = (backlight_code == `MLM_BL_CODE_ON) || (next_bl_cnt < `MLM_BACKLIGHT_S);
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      integ_cnt <= 4'h0;
      integ_tick <= 1'b0;
      heartbeat <= 1'b0;
      bl_cnt <= `MLM_BACKLIGHT_S;
      backlight_on <= 1'b0;
    end
    else
    begin
      integ_cnt <= next_integ_cnt;
      integ_tick <= next_integ_tick;
      heartbeat <= next_heartbeat;
      bl_cnt <= next_bl_cnt;
      backlight_on <= next_backlight_on;
    end
  end

  a_integ_mains: assert property ($past(mains_s) && next_integ_tick |-> integ_cnt >= 4'h1)
    else $error("integration tick early on mains");
  a_integ_batt: assert property (!mains_s && next_integ_tick |-> integ_cnt == 4'h7)
    else $error("integration tick not 8 s on battery");
  a_integ_sec: assert property (integ_tick |-> $past(sec_pulse))
    else $error("integration tick off the second grid");
  a_bl_forced: assert property ($past(backlight_code) == `MLM_BL_CODE_ON |-> backlight_on)
    else $error("backlight off with code 9");
  sequence s_key_hit;
    key_edge ##1 1'b1;
  endsequence
  a_bl_key: assert property (s_key_hit |-> backlight_on)
    else $error("backlight not lit after keystroke");
  a_heart_beat: assert property (sec_pulse |=> heartbeat != $past(heartbeat))
    else $error("heartbeat did not toggle");

  // ***************
  // Flow leak and burst
  // ***************
  mlm_pkg::mlm_acc_type dmass;
  mlm_pkg::mlm_acc_type burst_acc;
  logic [47:0] thr_acc;
  logic [31:0] leak_sec;
  logic [31:0] burst_sec;
  mlm_pkg::mlm_acc_type next_dmass;
  mlm_pkg::mlm_acc_type next_burst_acc;
  logic [47:0] next_thr_acc;
  logic [31:0] next_leak_sec;
  logic [31:0] next_burst_sec;
  logic next_leak_flag;
  logic next_burst_flag;
  mlm_pkg::mlm_acc_type term;
  logic [47:0] thr_term;
  logic [47:0] pm;
  logic [47:0] pc;
  logic leak_end;
  logic burst_end;

  always_comb
  begin
    pm = (leak_limit_code <= 3'h2) ? `MLM_LEAK_PM_WIDE : `MLM_LEAK_PM_NARROW;
    pc = leak_limit_code[0] ? `MLM_LEAK_PC_WIDE : `MLM_LEAK_PC_NARROW;
    term = 48'(signed'({1'b0, flow_input_one}) - signed'({1'b0, flow_input_two}))
      * signed'({44'h0, period});
    thr_term = (48'(nominal_flow) * pm + 48'(flow_input_one) * pc * `MLM_PC_SCALE)
      * {44'h0, period};
    leak_end = sec_pulse && (leak_sec >= LEAK_WINDOW_S - 1);
    burst_end = sec_pulse && (burst_sec >= BURST_WINDOW_S - 1);
    next_dmass = dmass;
    next_burst_acc = burst_acc;
    next_thr_acc = thr_acc;
    next_leak_sec = leak_sec;
    next_burst_sec = burst_sec;
    next_leak_flag = leak_flag;
    next_burst_flag = burst_flag;
    if (integ_tick)
    begin
      next_dmass = dmass + term;
      next_thr_acc = thr_acc + thr_term;
      next_burst_acc = burst_acc + term;
    end
    if (sec_pulse)
    begin
      next_leak_sec = leak_sec + 32'h00000001;
      next_burst_sec = burst_sec + 32'h00000001;
    end
    if (leak_end)
    begin
      next_leak_flag = 64'(mlm_abs(dmass)) * `MLM_LEAK_SCALE > 64'(thr_acc);
      next_dmass = '0;
      next_thr_acc = '0;
      next_leak_sec = 32'h00000000;
    end
    if (burst_end)
    begin
      next_burst_flag = mlm_abs(burst_acc) > 48'(nominal_flow) * `MLM_BURST_FACTOR;
      next_burst_acc = '0;
      next_burst_sec = 32'h00000000;
    end
    if (leak_limit_code == 3'h0)
    begin
      next_dmass = '0;
      next_burst_acc = '0;
      next_thr_acc = '0;
      next_leak_sec = 32'h00000000;
      next_burst_sec = 32'h00000000;
      next_leak_flag = 1'b0;
      next_burst_flag = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      dmass <= '0;
      burst_acc <= '0;
      thr_acc <= '0;
      leak_sec <= 32'h00000000;
      burst_sec <= 32'h00000000;
      leak_flag <= 1'b0;
      burst_flag <= 1'b0;
    end
    else
    begin
      dmass <= next_dmass;
      burst_acc <= next_burst_acc;
      thr_acc <= next_thr_acc;
      leak_sec <= next_leak_sec;
      burst_sec <= next_burst_sec;
      leak_flag <= next_leak_flag;
      burst_flag <= next_burst_flag;
    end
  end

  a_leak_hold: assert property (!leak_end && leak_limit_code != 3'h0 |=> $stable(leak_flag))
    else $error("leak flag moved outside day end");
  a_burst_hold: assert property (!burst_end && leak_limit_code != 3'h0 |=> $stable(burst_flag))
    else $error("burst flag moved outside window end");
  a_leak_off: assert property (leak_limit_code == 3'h0 |=> !leak_flag && !burst_flag)
    else $error("flag set with leak code zero");

  // ***************
  // Cold water supervision
  // ***************
  mlm_pkg::mlm_cold_mode_type cold_mode;
  logic [15:0] sub_len;
  logic [5:0] subs_needed;
  mlm_pkg::mlm_cold_mode_type cold_mode_q;
  logic cold_restart;

  always_comb
  begin
    cold_mode = mlm_pkg::mlm_cold_mode_type'(cold_code_valid ? cold_code : `MLM_COLD_DEFAULT_CODE);
    sub_len = 16'(COLD_UNIT_S);
    subs_needed = `MLM_COLD_SUBS_HALF;
    unique case (cold_mode)
      mlm_pkg::MLM_COLD_OFF: subs_needed = `MLM_COLD_SUBS_HALF;
      mlm_pkg::MLM_COLD_HALF: subs_needed = `MLM_COLD_SUBS_HALF;
      mlm_pkg::MLM_COLD_ONE:
      begin
        sub_len = 16'(COLD_UNIT_S) << 1;
        subs_needed = `MLM_COLD_SUBS_ONE;
      end
      mlm_pkg::MLM_COLD_TWO:
      begin
        sub_len = 16'(COLD_UNIT_S) << 2;
        subs_needed = `MLM_COLD_SUBS_TWO;
      end
    endcase
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cold_mode_q <= mlm_pkg::MLM_COLD_OFF;
    end
    else
    begin
      cold_mode_q <= cold_mode;
    end
  end

  assign cold_restart = (cold_mode != cold_mode_q);

  for (genvar i = 0; i < 2; i++)
  begin : g_cold
    logic [15:0] sub_sec;
    logic seen;
    logic [5:0] run;
    logic flag;
    logic [15:0] next_sub_sec;
    logic next_seen;
    logic [5:0] next_run;
    logic next_flag;
    logic en;
    logic sub_end;

    always_comb
    begin
      en = (cold_mode != mlm_pkg::MLM_COLD_OFF) && ((i == 0) || cold_supervise_b);
      sub_end = sec_pulse && (sub_sec + 16'h0001 >= sub_len);
      next_sub_sec = sub_sec;
      next_seen = seen | pulse_edge[i];
      next_run = run;
      next_flag = flag;
      if (sec_pulse)
      begin
        next_sub_sec = sub_sec + 16'h0001;
      end
      if (sub_end)
      begin
        next_sub_sec = 16'h0000;
        next_seen = 1'b0;
        if (seen | pulse_edge[i])
        begin
          next_run = (run < subs_needed) ? run + 6'h01 : subs_needed;
          next_flag = (next_run >= subs_needed);
        end
        else
        begin
          next_run = 6'h00;
          next_flag = 1'b0;
        end
      end
      if (!en || cold_restart)
      begin
        next_sub_sec = 16'h0000;
        next_seen = 1'b0;
        next_run = 6'h00;
        next_flag = 1'b0;
      end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
      if (!reset_n)
      begin
        sub_sec <= 16'h0000;
        seen <= 1'b0;
        run <= 6'h00;
        flag <= 1'b0;
      end
      else
      begin
        sub_sec <= next_sub_sec;
        seen <= next_seen;
        run <= next_run;
        flag <= next_flag;
      end
    end

    assign cold_leak_flag[i] = flag;

    a_cold_rise: assert property ($rose(flag) |-> $past(sub_end) && $past(run) == subs_needed - 6'h01)
      else $error("cold leak flag rose before full day");
    a_cold_clear: assert property (sub_end && !(seen | pulse_edge[i]) |=> !flag)
      else $error("cold leak flag kept after empty interval");
  end

  a_cold_b_off: assert property (!cold_supervise_b |=> !cold_leak_flag[1])
    else $error("second input supervised without enable");
endmodule
`default_nettype wire

// ==== sim/mlm_water_meter_model.sv ====
// Pulse-emitting cold water meter model for the meter leak monitor bench
`timescale 1ns/1ps
`default_nettype none
module mlm_water_meter_model
(
  // Clock
  input wire logic clk,
  // Control
  input wire logic enable,
  input wire logic [15:0] gap,
  // Pulse pins
  output logic pulse_a,
  output logic pulse_b
);
  logic [15:0] count = 16'h0000;
  initial
  begin
    pulse_a = 1'b0;
    pulse_b = 1'b0;
  end
  // ****************************************
  // Pulse train, five cycles wide, idle low
  // ****************************************
  always @(negedge clk)
  begin
    if (enable !== 1'b1)
      count <= 16'h0000;
    else if (count >= gap - 16'h0001)
      count <= 16'h0000;
    else
      count <= count + 16'h0001;
    pulse_a <= (enable === 1'b1) && (count < 16'h0005);
    pulse_b <= (enable === 1'b1) && (count >= gap / 2) && (count < gap / 2 + 16'h0005);
  end
endmodule
`default_nettype wire

// ==== sim/tb_meter_leak_monitor.sv ====
// Self-checking testbench of the meter leak monitor
`timescale 1ns/1ps
`default_nettype none
module tb_meter_leak_monitor;
  localparam int SEC = 10;
  localparam int LIMIT = 15000;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic mains_present = 1'b1;
  logic key_press = 1'b0;
  logic [3:0] backlight_code = 4'h4;
  logic [2:0] leak_limit_code = 3'h0;
  logic cold_code_valid = 1'b1;
  logic [1:0] cold_code = 2'h0;
  logic cold_supervise_b = 1'b0;
  mlm_pkg::mlm_flow_type flow_input_one = 16'h0000;
  mlm_pkg::mlm_flow_type flow_input_two = 16'h0000;
  mlm_pkg::mlm_flow_type nominal_flow = 16'h0000;
  logic cold_pulse_a;
  logic cold_pulse_b;
  logic integ_tick;
  logic heartbeat;
  logic backlight_on;
  logic leak_flag;
  logic burst_flag;
  logic [1:0] cold_leak_flag;
  logic meter_on = 1'b0;
  logic [15:0] meter_gap = 16'h000F;
  logic hb_prev = 1'b0;
  logic [31:0] seed = 32'h7D1A510E;
  int fails = 0;
  int check_count = 0;
  int cyc = 0;
  int tick_last = -1;
  int hb_last = -1;
  int k;
  int note_kind[$];
  int note_val[$];
  string names[6] = '{"tick period", "backlight", "leak flag", "burst flag", "cold a", "cold b"};

  always #50 clk = ~clk;

  mlm_meter_leak_monitor #(.SEC_CYCLES(SEC), .LEAK_WINDOW_S(20), .BURST_WINDOW_S(6),
    .COLD_UNIT_S(2)) dut (.clk, .reset_n, .mains_present, .key_press, .backlight_code,
    .leak_limit_code, .cold_code_valid, .cold_code, .cold_supervise_b, .flow_input_one,
    .flow_input_two, .nominal_flow, .cold_pulse_a, .cold_pulse_b, .integ_tick, .heartbeat,
    .backlight_on, .leak_flag, .burst_flag, .cold_leak_flag);

  mlm_water_meter_model meter (.clk, .enable(meter_on), .gap(meter_gap),
    .pulse_a(cold_pulse_a), .pulse_b(cold_pulse_b));

  // ****************************************
  // Checking and reporting
  // ****************************************
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("wrong value %s expected %0d seen %0d", what, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    if (note_kind.size() != 0)
      fails++;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  function automatic int note_take();
    int v;
    v = note_val.pop_front();
    void'(note_kind.pop_front());
    return v;
  endfunction

  function automatic logic pick(int n);
    case (n)
      1: return backlight_on;
      2: return leak_flag;
      3: return burst_flag;
      4: return cold_leak_flag[0];
      default: return cold_leak_flag[1];
    endcase
  endfunction

  function automatic logic [31:0] xorshift(logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction

  always @(posedge clk)
  begin
    cyc = cyc + 1;
    if (cyc == LIMIT)
    begin
      fails++;
      report_and_stop();
    end
    if (reset_n === 1'b1 && integ_tick === 1'b1)
    begin
      if (tick_last >= 0 && note_kind.size() > 0 && note_kind[0] == 0)
        check(names[0], 32'(cyc - tick_last), 32'(note_take()));
      tick_last = cyc;
    end
    if (reset_n === 1'b1 && heartbeat !== hb_prev)
    begin
      if (hb_last >= 0)
        check("heartbeat", 32'(cyc - hb_last), 32'(SEC));
      hb_last = cyc;
    end
    hb_prev = heartbeat;
    if (note_kind.size() > 0 && note_kind[0] != 0)
    begin
      k = note_kind[0];
      check(names[k], {31'h0, pick(k)}, 32'(note_take()));
    end
  end

  // ****************************************
  // Stimulus
  // ****************************************
  task automatic wait_cyc(int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic note(int n, int v);
    note_kind.push_back(n);
    note_val.push_back(v);
    if (n != 0)
    begin
      @(negedge clk);
    end
  endtask

  task automatic wait_tick(int n);
    for (int i = 0; i < 400 && n > 0; i++)
    begin
      @(negedge clk);
      if (integ_tick === 1'b1)
        n--;
    end
  endtask

  task automatic tick_period(logic mains, int exp);
    mains_present = mains;
    wait_tick(2);
    note(0, exp);
    wait_tick(1);
  endtask

  task automatic leak_case(logic [2:0] code, int f1, int f2, int qp, logic el, logic eb);
    leak_limit_code = 3'h0;
    wait_cyc(3);
    flow_input_one = 16'(f1);
    flow_input_two = 16'(f2);
    nominal_flow = 16'(qp);
    leak_limit_code = code;
    wait_cyc(30);
    note(2, 0);
    note(3, 0);
    wait_cyc(200);
    note(2, el);
    note(3, eb);
  endtask

  task automatic cold_case(logic valid, logic [1:0] code, int gap, logic sup_b, logic e0,
    logic e1);
    cold_code_valid = 1'b1;
    cold_code = 2'h0;
    meter_on = 1'b0;
    wait_cyc(3);
    cold_code_valid = valid;
    cold_code = code;
    cold_supervise_b = sup_b;
    meter_gap = 16'(gap);
    meter_on = 1'b1;
    wait_cyc(850);
    note(4, 0);
    note(5, 0);
    wait_cyc(150);
    note(4, e0);
    note(5, e1);
  endtask

  initial
  begin
    repeat (2) @(posedge clk);
    @(negedge clk);
    reset_n = 1'b1;
    tick_period(1'b1, 2 * SEC);
    tick_period(1'b0, 8 * SEC);
    tick_period(1'b1, 2 * SEC);
    key_press = 1'b1;
    wait_cyc(4);
    key_press = 1'b0;
    note(1, 1);
    wait_cyc(130);
    note(1, 1);
    wait_cyc(20);
    note(1, 0);
    backlight_code = 4'h9;
    wait_cyc(3);
    note(1, 1);
    wait_cyc(200);
    note(1, 1);
    for (int c = 1; c <= 4; c++)
      leak_case(3'(c), 100, 78, 1000, c % 2 == 0, 1'b0);
    seed = xorshift(seed);
    leak_case(3'h1, int'(seed % 1000), int'(seed % 1000), 1000, 1'b0, 1'b0);
    leak_case(3'h3, 0, 1000, 100, 1'b1, 1'b1);
    leak_case(3'h0, 0, 1000, 100, 1'b0, 1'b0);
    cold_case(1'b0, 2'h0, 30, 1'b0, 1'b1, 1'b0);
    cold_case(1'b1, 2'h1, 30, 1'b1, 1'b0, 1'b0);
    cold_case(1'b1, 2'h0, 15, 1'b1, 1'b0, 1'b0);
    cold_case(1'b1, 2'h3, 30, 1'b1, 1'b1, 1'b1);
    meter_on = 1'b0;
    wait_cyc(170);
    note(4, 0);
    note(5, 0);
    report_and_stop();
  end
endmodule
`default_nettype wire
